/* wdu_pkg.sv */
// Shared constants for the watchdog timer unit
// Overview of operation
// R1: Terminal count resets the processor core
// R2: Idle after reset until first instruction; the code stays idle until the first watchdog instruction (wdt_instr) instead
// R3: Later instructions restart the period
// R4: Counter advances on RC oscillator ticks
// R5: Instruction updates zero, sign, overflow flags
// R6: Mode bits 1:0 select timeout tap
// R7: Mode bit 2 keeps counting in halt
// R8: Mode bit 3 keeps counting in stop
// R9: Mode bits 7:4 reserved, no effect
// R10: Writes accepted 120 crystal clocks after start
// R11: Later writes ignored until qualifying event
// R12: Mode register reads back as zero
// R13: Mode register at bank F, 0Fh
// R14: Tap periods and reset mode are parameters
`default_nettype none
package wdu_pkg;
    // Register addresses: bank in [11:8], location in [7:0]
    localparam logic [11:0] WDU_ADDR_MODE = 12'hF0F;
    localparam logic [11:0] WDU_ADDR_STAT = 12'hF0E;
    // Mode register fields
    localparam int WDU_MODE_TAP_LSB = 0;
    localparam int WDU_MODE_HALT    = 2;
    localparam int WDU_MODE_STOP    = 3;
    localparam logic [3:0] WDU_MODE_RST = 4'h0;
    // Status register fields
    localparam int WDU_STAT_RUN  = 0;
    localparam int WDU_STAT_WIN  = 1;
    localparam int WDU_STAT_WRST = 2;
    // Tap periods in RC ticks
    localparam logic [15:0] WDU_PER0 = 16'h0100;
    localparam logic [15:0] WDU_PER1 = 16'h0200;
    localparam logic [15:0] WDU_PER2 = 16'h0400;
    localparam logic [15:0] WDU_PER3 = 16'h0800;
    // Write window in crystal clocks (two per processor cycle)
    localparam logic [6:0] WDU_WIN_CLKS = 7'd120;
    // Core reset pulse length in clocks
    localparam logic [2:0] WDU_RST_LEN = 3'h4;
    // Flag values written by the instruction (undefined, chosen zero)
    localparam logic [2:0] WDU_FLAG_VAL = 3'h0;
endpackage
`default_nettype wire

/* wdu_ctl_if.sv */
// Control bundle between the watchdog top and its counter
`default_nettype none
interface wdu_ctl_if;
    logic       restart; // Clear count to start of period
    logic       run;     // Counting allowed
    logic       tick;    // RC oscillator tick
    logic [1:0] tap;     // Period select
    logic       expire;  // Terminal count pulse
    modport top (output restart, run, tick, tap, input expire);
    modport cnt (input restart, run, tick, tap, output expire);
endinterface
`default_nettype wire

/* wdu_count.sv */
// Watchdog period counter with tap select
`default_nettype none
module wdu_count
    import wdu_pkg::*;
(
    input  wire logic clk_sys, // System clock
    input  wire logic rst,     // Synchronous reset
    wdu_ctl_if.cnt    c        // Control bundle
);
    logic [15:0] cnt_q;  // Ticks counted in period
    logic [15:0] cnt_d;  // Next count
    logic        exp_q;  // Terminal pulse
    logic [15:0] lim;    // Selected period
    logic        hit;    // Terminal reached this tick

    // Period selection from tap bits
    assign lim = (c.tap == 2'h0) ? WDU_PER0 :
                 (c.tap == 2'h1) ? WDU_PER1 :
                 (c.tap == 2'h2) ? WDU_PER2 : WDU_PER3; // see R6
    assign hit = c.run && c.tick && (cnt_q >= lim - 16'h0001); // see R1
    assign cnt_d = (c.restart || hit) ? 16'h0000 :
                   (c.run && c.tick) ? cnt_q + 16'h0001 : cnt_q; // see R3, see R4
    assign c.expire = exp_q;

    // Count and terminal pulse
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_q <= 16'h0000;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            exp_q <= hit && !c.restart;
        end
    end
endmodule
`default_nettype wire

/* wdu_win.sv */
// Mode register write window timer
`default_nettype none
module wdu_win
    import wdu_pkg::*;
(
    input  wire logic clk_sys,     // System (crystal) clock
    input  wire logic rst,         // Synchronous reset, qualifies window
    input  wire logic arm,         // Watchdog reset or stop recovery
    input  wire logic first_instr, // First instruction executed
    output logic      open_q       // Writes accepted
);
    logic       pend_q; // Waiting for first instruction
    logic [6:0] cnt_q;  // Clocks spent open

    // Window opens on the first instruction after a qualifying event
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pend_q <= 1'b1;
            open_q <= 1'b0;
            cnt_q  <= 7'h00;
        end
        else if (arm)
        begin
            pend_q <= 1'b1;
            open_q <= 1'b0;
            cnt_q  <= 7'h00;
        end
        else if (pend_q && first_instr)
        begin
            pend_q <= 1'b0;
            open_q <= 1'b1; // see R10
            cnt_q  <= 7'h00;
        end
        else if (open_q)
        begin
            // Close after the last allowed clock
            open_q <= (cnt_q != WDU_WIN_CLKS - 7'd1); // see R10, see R11
            cnt_q  <= cnt_q + 7'd1;
        end
        else
        begin
            cnt_q <= cnt_q;
        end
    end
endmodule
`default_nettype wire

/* wdu_top.sv */
// Watchdog timer unit top: mode register, run control, core reset
//
// Chosen here: the address-and-strobe port.
`default_nettype none
module wdu_top
    import wdu_pkg::*;
(
    input  wire logic        clk_sys,      // System clock, 100 MHz
    input  wire logic        rst,          // Synchronous reset, power-on
    input  wire logic        rc_tick,      // RC oscillator tick pulse
    input  wire logic        wdt_instr,    // Core executed watchdog instruction
    input  wire logic        first_instr,  // Core executed first instruction
    input  wire logic        halt_state,   // Core in halt
    input  wire logic        stop_state,   // Core in stop
    input  wire logic        stop_recover, // Stop-mode recovery pulse
    input  wire logic [11:0] addr,         // Register address
    input  wire logic [7:0]  wdata,        // Write data
    input  wire logic        wr,           // Write strobe
    input  wire logic        rd,           // Read strobe
    output logic      [7:0]  rdata_q,      // Read data, cycle after rd
    output logic             core_reset_q, // Core reset request
    output logic             flag_we_q,    // Core flag update strobe
    output logic      [2:0]  flag_zsv_q    // Zero, sign, overflow values
);
    // Internal state
    logic       running_q; // Watchdog armed
    logic [3:0] mode_q;    // Mode bits kept (tap, halt, stop)
    logic [3:0] mode_d;    // Next mode
    logic       wrst_q;    // Watchdog reset happened, sticky
    logic       wrst_d;    // Next sticky flag
    logic [2:0] rcnt_q;    // Core reset pulse counter
    logic [2:0] rcnt_d;    // Next pulse count
    logic       win_open;  // Mode write window
    logic [7:0] rd_mux;    // Read selection

    // Decode
    wire sel_mode  = (addr == WDU_ADDR_MODE); // see R13
    wire sel_stat  = (addr == WDU_ADDR_STAT);
    wire mode_wr   = wr && sel_mode && win_open; // see R10, see R11
    wire stat_wr   = wr && sel_stat;
    wire halt_hold = halt_state && !mode_q[WDU_MODE_HALT]; // see R7
    wire stop_hold = stop_state && !mode_q[WDU_MODE_STOP]; // see R8

    wdu_ctl_if ctl ();

    // Counter bundle drive
    assign ctl.restart = wdt_instr; // see R2, see R3
    assign ctl.run     = running_q && !halt_hold && !stop_hold;
    assign ctl.tick    = rc_tick; // see R4
    assign ctl.tap     = mode_q[WDU_MODE_TAP_LSB +: 2]; // see R6

    wdu_count u_count (
        .clk_sys (clk_sys),
        .rst     (rst),
        .c       (ctl)
    );

    wdu_win u_win (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .arm         (ctl.expire || stop_recover),
        .first_instr (first_instr),
        .open_q      (win_open)
    );

    // Mode: only low four bits are stored; reserved bits dropped
    assign mode_d = ctl.expire ? WDU_MODE_RST :
                    mode_wr ? wdata[3:0] : mode_q; // see R9, see R14
    // Sticky flag: set wins over a software clear
    assign wrst_d = ctl.expire ? 1'b1 :
                    (stat_wr && wdata[WDU_STAT_WRST]) ? 1'b0 : wrst_q;
    // Reset pulse length
    assign rcnt_d = ctl.expire ? WDU_RST_LEN :
                    (rcnt_q != 3'h0) ? rcnt_q - 3'h1 : 3'h0;
    // Read mux: mode location reads zero
    assign rd_mux = sel_stat ? {5'h00, wrst_q, win_open, running_q} :
                    8'h00; // see R12

    // Arm state: watchdog instruction starts, expiry disarms
    always_ff @(posedge clk_sys)
    begin
        if (rst || ctl.expire)
            running_q <= 1'b0;
        else if (wdt_instr)
            running_q <= 1'b1; // see R2
        else
            running_q <= running_q;
    end

    // Mode and sticky status
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mode_q <= WDU_MODE_RST; // see R14
            wrst_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            wrst_q <= wrst_d;
        end
    end

    // Core reset pulse
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rcnt_q       <= 3'h0;
            core_reset_q <= 1'b0;
        end
        else
        begin
            rcnt_q       <= rcnt_d;
            core_reset_q <= (rcnt_d != 3'h0); // see R1
        end
    end

    // Flag update for the instruction
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            flag_we_q  <= 1'b0;
            flag_zsv_q <= 3'h0;
        end
        else
        begin
            flag_we_q  <= wdt_instr; // see R5
            flag_zsv_q <= WDU_FLAG_VAL;
        end
    end

    // Read data register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdata_q <= 8'h00;
        else
            rdata_q <= rd ? rd_mux : 8'h00;
    end

    // Helper: length of current open window
    logic [7:0] win_len_q; // Clocks open so far
    always_ff @(posedge clk_sys)
    begin
        if (rst || !win_open)
            win_len_q <= 8'h00;
        else
            win_len_q <= win_len_q + 8'h01;
    end

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_reset_pulse: assert property ( // see R1
        ctl.expire |=> core_reset_q [*4] ##1 !core_reset_q || ctl.expire)
        else $error("core reset pulse length wrong");

    chk_arm_cause: assert property ( // see R2
        $rose(running_q) |-> $past(wdt_instr))
        else $error("watchdog armed without instruction");

    chk_refresh_stops: assert property ( // see R3
        wdt_instr |=> !ctl.expire)
        else $error("expiry right after refresh");

    chk_tick_cause: assert property ( // see R4
        ctl.expire |-> $past(rc_tick) && $past(ctl.run))
        else $error("expiry without RC tick");

    chk_flag_touch: assert property ( // see R5
        wdt_instr |=> flag_we_q && flag_zsv_q == WDU_FLAG_VAL)
        else $error("flags not updated by instruction");

    chk_tap_follow: assert property ( // see R6
        mode_wr && !ctl.expire |=> ctl.tap == $past(wdata[1:0]))
        else $error("tap not taken from mode bits");

    chk_halt_freeze: assert property ( // see R7
        halt_state && !mode_q[2] |-> !ctl.run)
        else $error("counting in halt while disabled");

    chk_stop_freeze: assert property ( // see R8
        stop_state && !mode_q[3] |-> !ctl.run)
        else $error("counting in stop while disabled");

    chk_mode_write: assert property ( // see R9
        wr && sel_mode && win_open && !ctl.expire |=> mode_q == $past(wdata[3:0]))
        else $error("mode write not stored");

    chk_window_len: assert property ( // see R10
        win_len_q <= 8'd120)
        else $error("write window too long");

    chk_window_block: assert property ( // see R11
        wr && sel_mode && !win_open && !ctl.expire |=> $stable(mode_q))
        else $error("mode changed outside window");

    chk_write_only: assert property ( // see R12
        rd && sel_mode |=> rdata_q == 8'h00)
        else $error("mode register readable");

    chk_sticky_set: assert property (
        ctl.expire |=> wrst_q)
        else $error("sticky flag lost");

    cov_refresh: cover property (running_q && wdt_instr);
    cov_expire: cover property (ctl.expire);
    cov_mode_wr: cover property (mode_wr);
    cov_late_wr: cover property (wr && sel_mode && !win_open);
endmodule
`default_nettype wire

/* wdu_core_model.sv */
// Core-side model: free-running RC ticks and instruction pulses
`default_nettype none
module wdu_core_model
(
    input  wire logic clk_sys,     // System clock
    input  wire logic rst,         // Synchronous reset
    input  wire logic go_wdt,      // Request a watchdog instruction
    input  wire logic go_first,    // Request a first instruction
    output logic      rc_tick,     // RC tick, every second clock
    output logic      wdt_instr,   // Watchdog instruction pulse
    output logic      first_instr  // First instruction pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // RC oscillator runs free, slower than the system clock
    always_ff @(posedge clk_sys)
    begin
        rc_tick     <= rst ? 1'b0 : ~rc_tick;
        wdt_instr   <= go_wdt & ~rst;         // One-cycle instruction
        first_instr <= go_first & ~rst;       // One-cycle instruction
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the watchdog timer unit
`default_nettype none
module tb_top
    import wdu_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, halt_state, stop_state, stop_recover; // Control inputs
    logic [11:0] addr;                                           // Register address
    logic [7:0]  wdata, rdata_q, rv;                             // Bus data
    logic        wr, rd, go_wdt, go_first, rc_tick, wdt_instr;   // Strobes
    logic        first_instr, core_reset_q, flag_we_q;           // Core side
    logic [2:0]  flag_zsv_q;                                     // Flag values
    int          n_mismatch, checks, cyc;                        // Counters

    wdu_core_model core (.clk_sys(clk_sys), .rst(rst), .go_wdt(go_wdt), .go_first(go_first),
        .rc_tick(rc_tick), .wdt_instr(wdt_instr), .first_instr(first_instr));
    wdu_top dut (.clk_sys(clk_sys), .rst(rst), .rc_tick(rc_tick), .wdt_instr(wdt_instr),
        .first_instr(first_instr), .halt_state(halt_state), .stop_state(stop_state),
        .stop_recover(stop_recover), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .core_reset_q(core_reset_q), .flag_we_q(flag_we_q), .flag_zsv_q(flag_zsv_q));

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // Hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 d = rdata_q;
    endtask

    // Ask the core for one instruction: watchdog when w, else first
    task automatic instr(input logic w);
        @(posedge clk_sys);
        go_wdt   <= w;
        go_first <= ~w;
        @(posedge clk_sys);
        go_wdt   <= 1'b0;
        go_first <= 1'b0;
    endtask

    // No core reset may appear for n cycles
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n)
        begin
            @(posedge clk_sys);
            #1 seen = seen | core_reset_q;
        end
        check({15'h0, seen}, 16'h0000);
    endtask

    // Core reset expected about nom cycles on, then held four cycles
    task automatic expect_reset(input int nom);
        int n;
        n = 0;
        while (core_reset_q !== 1'b1 && n < nom + 40)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        check({15'h0, n >= nom - 8 && n <= nom + 8}, 16'h0001);
        repeat (3) @(posedge clk_sys);
        #1 check({15'h0, core_reset_q}, 16'h0001);
        @(posedge clk_sys);
        #1 check({15'h0, core_reset_q}, 16'h0000);
    endtask

    initial
    begin
        {clk_sys, halt_state, stop_state, stop_recover, wr, rd, go_wdt, go_first} = '0;
        {addr, wdata, n_mismatch, checks, cyc} = '0;
        rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        quiet(600);
        rd_reg(WDU_ADDR_STAT, rv);
        check({8'h00, rv}, 16'h0000);
        instr(1'b0);
        rd_reg(WDU_ADDR_STAT, rv);
        check({8'h00, rv}, 16'h0002);
        wr_reg(WDU_ADDR_MODE, 8'hF0);
        wr_reg(12'h10F, 8'h03);
        rd_reg(WDU_ADDR_MODE, rv);
        check({8'h00, rv}, 16'h0000);
        rd_reg(12'h10F, rv);
        check({8'h00, rv}, 16'h0000);
        repeat (125) @(posedge clk_sys);
        wr_reg(WDU_ADDR_MODE, 8'h03);
        rd_reg(WDU_ADDR_STAT, rv);
        check({8'h00, rv}, 16'h0000);
        instr(1'b1);
        @(posedge clk_sys);
        #1 check({12'h0, flag_we_q, flag_zsv_q}, {12'h0, 1'b1, WDU_FLAG_VAL});
        rd_reg(WDU_ADDR_STAT, rv);
        check({8'h00, rv}, 16'h0001);
        repeat (3)
        begin
            repeat (400) @(posedge clk_sys);
            instr(1'b1);
        end
        expect_reset(2 * WDU_PER0 + 2);
        rd_reg(WDU_ADDR_STAT, rv);
        check({8'h00, rv}, 16'h0004);
        wr_reg(WDU_ADDR_STAT, 8'h04);
        rd_reg(WDU_ADDR_STAT, rv);
        check({8'h00, rv}, 16'h0000);
        // Halt freezes the count while mode bit 2 is clear
        instr(1'b0);
        instr(1'b1);
        halt_state <= 1'b1;
        quiet(1200);
        halt_state <= 1'b0;
        expect_reset(2 * WDU_PER0 + 2);
        // Tap one, counting through halt
        instr(1'b0);
        wr_reg(WDU_ADDR_MODE, 8'h05);
        rd_reg(WDU_ADDR_MODE, rv);
        check({8'h00, rv}, 16'h0000);
        instr(1'b1);
        halt_state <= 1'b1;
        expect_reset(2 * WDU_PER1 + 2);
        halt_state <= 1'b0;
        // Let a window lapse; stop recovery must reopen it; tap two, counting through stop
        instr(1'b0);
        repeat (125) @(posedge clk_sys);
        @(posedge clk_sys);
        stop_recover <= 1'b1;
        @(posedge clk_sys);
        stop_recover <= 1'b0;
        instr(1'b0);
        wr_reg(WDU_ADDR_MODE, 8'h0A);
        instr(1'b1);
        stop_state <= 1'b1;
        expect_reset(2 * WDU_PER2 + 2);
        stop_state <= 1'b0;
        // Stop freezes the count while mode bit 3 is clear
        instr(1'b0);
        instr(1'b1);
        stop_state <= 1'b1;
        quiet(1200);
        stop_state <= 1'b0;
        expect_reset(2 * WDU_PER0 + 2);
        finish_test();
    end
endmodule
`default_nettype wire
